// ==== hw/key_wake_standby.sv ====
// What this block does
// - release pin plus four key pins release standby
// - enable register, bits 7..4, upper reset zero
// - enable bits write only, read returns zero
// - one enable bit per key pin
// - exit standby on low enabled key pin, level mode only
// - release condition at entry: no standby, warm-up
// - level mode: levels; edge mode: rising release pin
// - release pin always acts, no enable bit
//
// Register access over AXI4-Lite was decided locally.
module key_wake_standby (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic [key_wake_pkg::ADDR_W-1:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic awvalid,
  output logic awready,
  input wire logic [key_wake_pkg::DATA_W-1:0] wdata,
  input wire logic [key_wake_pkg::STRB_W-1:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [key_wake_pkg::ADDR_W-1:0] araddr,
  input wire logic [2:0] arprot,
  input wire logic arvalid,
  output logic arready,
  output logic [key_wake_pkg::DATA_W-1:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic port2_bit0,
  input wire logic [key_wake_pkg::KEYS-1:0] keyWakePin,
  output logic standbyActive,
  output logic warmupStart,
  output logic releaseRequest,
  output logic irq
);
  import key_wake_pkg::*;

  typedef struct packed {
    pmode_t mode;
    logic [KEYS-1:0] keyEn;
    logic relLevel;
    logic [EVT_W-1:0] mask;
    logic [EVT_W-1:0] status;
    logic warmup;
    logic awHeld;
    logic [ADDR_W-1:0] awAddr;
    logic wHeld;
    logic [DATA_W-1:0] wData;
    logic [STRB_W-1:0] wStrb;
    logic bValid;
    logic [1:0] bResp;
    logic rValid;
    logic [DATA_W-1:0] rData;
    logic [1:0] rResp;
  } state_t;

  state_t cur_r;
  state_t cur_nxt;
  logic levelCond;

  // ----------------------------------------
  // address decode
  // ----------------------------------------
  function automatic regsel_t decode(input logic [ADDR_W-1:0] addr);
    regsel_t sel;
    sel = SEL_NONE;
    if (addr == ADDR_KEY_WAKE_ENABLE) begin
      sel = SEL_ENABLE;
    end else if (addr == ADDR_CONTROL) begin
      sel = SEL_CONTROL;
    end else if (addr == ADDR_STATUS) begin
      sel = SEL_STATUS;
    end else if (addr == ADDR_MASK) begin
      sel = SEL_MASK;
    end else if (addr == ADDR_PINS) begin
      sel = SEL_PINS;
    end
    return sel;
  endfunction : decode

  function automatic logic [1:0] respFor(input regsel_t sel);
    logic [1:0] resp;
    resp = RESP_OKAY;
    if (sel == SEL_NONE) begin
      resp = RESP_SLVERR;
    end
    return resp;
  endfunction : respFor

  function automatic logic [DATA_W-1:0] readWord(input regsel_t sel, input state_t s,
                                                 input logic rel, input logic [KEYS-1:0] keys);
    logic [DATA_W-1:0] word;
    word = DATA_ZERO;
    unique case (sel)
      SEL_NONE: begin
        word = DATA_ZERO;
      end
      SEL_ENABLE: begin
        word = DATA_ZERO;
      end
      SEL_CONTROL: begin
        word[CTRL_LEVEL_BIT] = s.relLevel;
      end
      SEL_STATUS: begin
        word[EVT_W-1:0] = s.status;
      end
      SEL_MASK: begin
        word[EVT_W-1:0] = s.mask;
      end
      SEL_PINS: begin
        word[PINS_REL_BIT] = rel;
        word[PINS_KEY_LSB +: KEYS] = keys;
        word[PINS_STBY_BIT] = (s.mode == MODE_STANDBY);
      end
      default: word = DATA_ZERO;
    endcase
    return word;
  endfunction : readWord

  // ----------------------------------------
  // release detection
  // ----------------------------------------
  wake_detect detect (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .releasePin(port2_bit0),
    .keyPin(keyWakePin),
    .keyEnable(cur_r.keyEn),
    .levelMode(cur_r.relLevel),
    .levelCond(levelCond),
    .releaseReq(releaseRequest)
  );

  // ----------------------------------------
  // bus handshakes
  // ----------------------------------------
  assign awready = !cur_r.awHeld && !cur_r.bValid;
  assign wready = !cur_r.wHeld && !cur_r.bValid;
  assign arready = !cur_r.rValid;
  assign bvalid = cur_r.bValid;
  assign bresp = cur_r.bResp;
  assign rvalid = cur_r.rValid;
  assign rdata = cur_r.rData;
  assign rresp = cur_r.rResp;

  // ----------------------------------------
  // pin side outputs and interrupt
  // ----------------------------------------
  assign standbyActive = (cur_r.mode == MODE_STANDBY);
  assign warmupStart = cur_r.warmup;
  assign irq = |(cur_r.status & cur_r.mask);

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    logic enterReq;
    logic [EVT_W-1:0] evt;
    logic [EVT_W-1:0] clr;
    regsel_t wsel;
    regsel_t rsel;
    enterReq = 1'h0;
    evt = EVT_RESET;
    clr = EVT_RESET;
    wsel = decode(cur_r.awAddr);
    rsel = decode(araddr);
    cur_nxt = cur_r;
    cur_nxt.warmup = 1'h0;

    // ----------------------------------------
    // address and data taken in either order
    // ----------------------------------------
    if (awvalid && awready) begin
      cur_nxt.awHeld = 1'h1;
      cur_nxt.awAddr = awaddr;
    end
    if (wvalid && wready) begin
      cur_nxt.wHeld = 1'h1;
      cur_nxt.wData = wdata;
      cur_nxt.wStrb = wstrb;
    end

    // ----------------------------------------
    // register write once both are held
    // ----------------------------------------
    if (cur_r.awHeld && cur_r.wHeld) begin
      cur_nxt.awHeld = 1'h0;
      cur_nxt.wHeld = 1'h0;
      cur_nxt.bValid = 1'h1;
      cur_nxt.bResp = respFor(wsel);
      if (cur_r.wStrb[0]) begin
        unique case (wsel)
          SEL_NONE: begin
            cur_nxt.bResp = RESP_SLVERR;
          end
          SEL_ENABLE: begin
            cur_nxt.keyEn = cur_r.wData[KEY_EN_LSB +: KEYS];
          end
          SEL_CONTROL: begin
            cur_nxt.relLevel = cur_r.wData[CTRL_LEVEL_BIT];
            enterReq = cur_r.wData[CTRL_ENTER_BIT];
          end
          SEL_STATUS: begin
            cur_nxt.bResp = RESP_OKAY;
          end
          SEL_MASK: begin
            cur_nxt.mask = cur_r.wData[EVT_W-1:0];
          end
          SEL_PINS: begin
            cur_nxt.bResp = RESP_OKAY;
          end
          default: begin
            cur_nxt.bResp = RESP_SLVERR;
          end
        endcase
      end
    end

    // ----------------------------------------
    // write response
    // ----------------------------------------
    if (cur_r.bValid && bready) begin
      cur_nxt.bValid = 1'h0;
    end

    // ----------------------------------------
    // register read
    // ----------------------------------------
    if (arvalid && arready) begin
      cur_nxt.rValid = 1'h1;
      cur_nxt.rData = readWord(rsel, cur_r, port2_bit0, keyWakePin);
      cur_nxt.rResp = respFor(rsel);
      if (rsel == SEL_STATUS) begin
        clr = cur_r.status;
      end
    end

    // ----------------------------------------
    // read response
    // ----------------------------------------
    if (cur_r.rValid && rready) begin
      cur_nxt.rValid = 1'h0;
    end

    // ----------------------------------------
    // standby entry and release
    // ----------------------------------------
    unique case (cur_r.mode)
      MODE_RUN: begin
        if (enterReq) begin
          if (levelCond) begin
            cur_nxt.warmup = 1'h1;
            evt[ST_BLOCKED_BIT] = 1'h1;
          end else begin
            cur_nxt.mode = MODE_STANDBY;
          end
        end
      end
      MODE_STANDBY: begin
        if (releaseRequest) begin
          cur_nxt.mode = MODE_RUN;
          cur_nxt.warmup = 1'h1;
          evt[ST_RELEASED_BIT] = 1'h1;
        end
      end
    endcase

    // ----------------------------------------
    // sticky events, set wins over read clear
    // ----------------------------------------
    cur_nxt.status = (cur_r.status & ~clr) | evt;
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      cur_r.mode <= MODE_RUN;
      cur_r.keyEn <= KEY_EN_RESET;
      cur_r.relLevel <= CTRL_LEVEL_RESET;
      cur_r.mask <= EVT_RESET;
      cur_r.status <= EVT_RESET;
      cur_r.warmup <= 1'h0;
      cur_r.awHeld <= 1'h0;
      cur_r.awAddr <= '0;
      cur_r.wHeld <= 1'h0;
      cur_r.wData <= DATA_ZERO;
      cur_r.wStrb <= '0;
      cur_r.bValid <= 1'h0;
      cur_r.bResp <= RESP_OKAY;
      cur_r.rValid <= 1'h0;
      cur_r.rData <= DATA_ZERO;
      cur_r.rResp <= RESP_OKAY;
    end else begin
      cur_r <= cur_nxt;
    end
  end

endmodule : key_wake_standby

// ==== hw/wake_detect.sv ====
module wake_detect (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic releasePin,
  input wire logic [key_wake_pkg::KEYS-1:0] keyPin,
  input wire logic [key_wake_pkg::KEYS-1:0] keyEnable,
  input wire logic levelMode,
  output logic levelCond,
  output logic releaseReq
);
  import key_wake_pkg::*;

  typedef struct packed {
    logic prevRelease;
  } det_t;

  det_t cur_r;
  det_t cur_nxt;

  // ----------------------------------------
  // release condition, no clock in the path
  // ----------------------------------------
  always_comb begin
    cur_nxt = cur_r;
    cur_nxt.prevRelease = releasePin;
    levelCond = releasePin | (|(keyEnable & ~keyPin));
    if (levelMode) begin
      releaseReq = levelCond;
    end else begin
      releaseReq = releasePin & ~cur_r.prevRelease;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      cur_r <= '0;
    end else begin
      cur_r <= cur_nxt;
    end
  end

endmodule : wake_detect

// ==== inc/key_wake_pkg.sv ====
package key_wake_pkg;

  // ----------------------------------------
  // bus and pin widths
  // ----------------------------------------
  localparam int ADDR_W = 16;
  localparam int DATA_W = 32;
  localparam int STRB_W = DATA_W / 8;
  localparam int KEYS = 4;
  localparam int EVT_W = 2;

  // ----------------------------------------
  // register indices and byte addresses
  // ----------------------------------------
  localparam logic [ADDR_W-1:0] IDX_KEY_WAKE_ENABLE = 16'h0f9f;
  localparam logic [ADDR_W-1:0] IDX_CONTROL = 16'h0fa0;
  localparam logic [ADDR_W-1:0] IDX_STATUS = 16'h0fa1;
  localparam logic [ADDR_W-1:0] IDX_MASK = 16'h0fa2;
  localparam logic [ADDR_W-1:0] IDX_PINS = 16'h0fa3;
  localparam logic [ADDR_W-1:0] ADDR_KEY_WAKE_ENABLE = {IDX_KEY_WAKE_ENABLE[ADDR_W-3:0], 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_CONTROL = {IDX_CONTROL[ADDR_W-3:0], 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_STATUS = {IDX_STATUS[ADDR_W-3:0], 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_MASK = {IDX_MASK[ADDR_W-3:0], 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_PINS = {IDX_PINS[ADDR_W-3:0], 2'h0};

  // ----------------------------------------
  // field positions and reset values
  // ----------------------------------------
  localparam int KEY_EN_LSB = 4;
  localparam logic [KEYS-1:0] KEY_EN_RESET = 4'h0;
  localparam int CTRL_LEVEL_BIT = 0;
  localparam int CTRL_ENTER_BIT = 1;
  localparam logic CTRL_LEVEL_RESET = 1'h1;
  localparam int ST_RELEASED_BIT = 0;
  localparam int ST_BLOCKED_BIT = 1;
  localparam logic [EVT_W-1:0] EVT_RESET = 2'h0;
  localparam int PINS_REL_BIT = 0;
  localparam int PINS_KEY_LSB = 4;
  localparam int PINS_STBY_BIT = 8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [DATA_W-1:0] DATA_ZERO = 32'h0;

  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic {
    MODE_RUN = 1'h0,
    MODE_STANDBY = 1'h1
  } pmode_t;

  typedef enum logic [2:0] {
    SEL_NONE = 3'h0,
    SEL_ENABLE = 3'h1,
    SEL_CONTROL = 3'h2,
    SEL_STATUS = 3'h3,
    SEL_MASK = 3'h4,
    SEL_PINS = 3'h5
  } regsel_t;

endpackage : key_wake_pkg

// ==== tb/key_pad.sv ====
module key_pad (
  input wire logic [key_wake_pkg::KEYS-1:0] keyPress,
  input wire logic relLevel,
  output logic [key_wake_pkg::KEYS-1:0] keyWakePin,
  output logic port2_bit0
);
  timeunit 1ns;
  timeprecision 100ps;
  import key_wake_pkg::*;
  // ----
  // switches to ground with pull-ups, digital only
  // ----
  assign keyWakePin = ~keyPress;
  // release line stays low unless raised
  assign port2_bit0 = relLevel;
endmodule : key_pad

// ==== tb/key_wake_properties.sv ====
module key_wake_properties (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic port2_bit0,
  input wire logic [key_wake_pkg::KEYS-1:0] keyWakePin,
  input wire logic standbyActive,
  input wire logic warmupStart,
  input wire logic releaseRequest,
  input wire logic bvalid,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [key_wake_pkg::ADDR_W-1:0] araddr,
  input wire logic rvalid,
  input wire logic [key_wake_pkg::DATA_W-1:0] rdata
);
  timeunit 1ns;
  timeprecision 100ps;
  import key_wake_pkg::*;
  // ----
  // standby and release checks
  // ----
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  sequence s_asleep; standbyActive && releaseRequest; endsequence
  sequence s_wake; !standbyActive && warmupStart; endsequence
  property p_exit; s_asleep |=> s_wake; endproperty
  a_exit: assert property (p_exit) else $error("standby kept on release");
  property p_hold; standbyActive && !releaseRequest |=> standbyActive; endproperty
  a_hold: assert property (p_hold) else $error("standby left without release");
  property p_pulse; warmupStart |=> !warmupStart; endproperty
  a_pulse: assert property (p_pulse) else $error("warmup pulse too long");
  property p_enter; $rose(standbyActive) |-> $rose(bvalid); endproperty
  a_enter: assert property (p_enter) else $error("standby without control write");
  property p_quiet; !port2_bit0 && &keyWakePin |-> !releaseRequest; endproperty
  a_quiet: assert property (p_quiet) else $error("release with idle pins");
  property p_fall; $fell(standbyActive) |-> warmupStart; endproperty
  a_fall: assert property (p_fall) else $error("exit without warmup");
  property p_wo; arvalid && arready && araddr == ADDR_KEY_WAKE_ENABLE |=> rvalid && rdata == DATA_ZERO; endproperty
  a_wo: assert property (p_wo) else $error("enable register readable");
  property p_blk; warmupStart && !$past(standbyActive) |-> $rose(bvalid); endproperty
  a_blk: assert property (p_blk) else $error("warmup without entry attempt");
endmodule : key_wake_properties

bind key_wake_standby key_wake_properties chk (.sys_clk(sys_clk), .rst_b(rst_b), .port2_bit0(port2_bit0),
  .keyWakePin(keyWakePin), .standbyActive(standbyActive), .warmupStart(warmupStart),
  .releaseRequest(releaseRequest), .bvalid(bvalid), .arvalid(arvalid), .arready(arready),
  .araddr(araddr), .rvalid(rvalid), .rdata(rdata));

// ==== tb/testbench.sv ====
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  import key_wake_pkg::*;
  logic sys_clk = 0;
  logic rst_b = 0;
  logic [ADDR_W-1:0] awaddr = '0;
  logic [ADDR_W-1:0] araddr = '0;
  logic [2:0] awprot = '0;
  logic [2:0] arprot = '0;
  logic [DATA_W-1:0] wdata = '0;
  logic [STRB_W-1:0] wstrb = '0;
  logic awvalid = 0;
  logic wvalid = 0;
  logic bready = 1;
  logic arvalid = 0;
  logic rready = 1;
  logic relLevel = 0;
  logic [KEYS-1:0] keyPress = '0;
  logic awready, wready, bvalid, arready, rvalid, standbyActive, warmupStart, releaseRequest, irq, port2_bit0;
  logic [1:0] bresp, rresp, rs;
  logic [DATA_W-1:0] rdata, rd;
  logic [KEYS-1:0] keyWakePin;
  int errCount = 0;
  int checksDone = 0;
  int warmSeen = 0;
  int warmExp = 0;
  int j;
  int keyEnModel = 0;
  // ----
  // clock, design, far side
  // ----
  always #5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (warmupStart === 1'b1) warmSeen++;
  key_wake_standby uut (.sys_clk(sys_clk), .rst_b(rst_b),
    .awaddr(awaddr), .awprot(awprot), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arprot(arprot), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .port2_bit0(port2_bit0), .keyWakePin(keyWakePin), .standbyActive(standbyActive),
    .warmupStart(warmupStart), .releaseRequest(releaseRequest), .irq(irq));
  key_pad pad (.keyPress(keyPress), .relLevel(relLevel), .keyWakePin(keyWakePin), .port2_bit0(port2_bit0));
  // ----
  // tasks
  // ----
  function automatic logic relModel(input logic rel, input logic [KEYS-1:0] press);
    return rel | (|(KEYS'(keyEnModel) & press));
  endfunction : relModel
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checksDone++;
    if (g !== e) begin
      errCount++;
      $display("unexpected %s exp %h got %h", n, e, g);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : tick
  task automatic axw(input logic [15:0] a, input logic [31:0] d);
    logic [1:0] er;
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awprot <= 3'($urandom);
    awvalid <= 1;
    wvalid <= 1;
    do begin
      @(posedge sys_clk);
      if (awvalid && awready) awvalid <= 0;
      if (wvalid && wready) wvalid <= 0;
    end while (bvalid !== 1'b1);
    er = (a inside {ADDR_KEY_WAKE_ENABLE, ADDR_CONTROL, ADDR_STATUS, ADDR_MASK, ADDR_PINS}) ?
      RESP_OKAY : RESP_SLVERR;
    chk("bresp", 32'(er), 32'(bresp));
    if (a == ADDR_KEY_WAKE_ENABLE) keyEnModel = int'(d[KEY_EN_LSB +: KEYS]);
  endtask : axw
  task automatic rc(input string n, input logic [15:0] a, input logic [31:0] e, input logic [1:0] er);
    araddr <= a;
    arprot <= 3'($urandom);
    arvalid <= 1;
    do begin
      @(posedge sys_clk);
      if (arvalid && arready) arvalid <= 0;
    end while (rvalid !== 1'b1);
    rd = rdata;
    rs = rresp;
    chk(n, e, rd);
    chk({n, "Resp"}, 32'(er), 32'(rs));
  endtask : rc
  task automatic waitRel;
    for (int k = 0; k < 8 && standbyActive !== 1'b0; k++) @(posedge sys_clk);
    tick(1);
  endtask : waitRel
  task automatic conclude;
    $display("checks %0d mismatches %0d", checksDone, errCount);
    if (errCount == 0 && checksDone > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : conclude
  // ----
  // tests
  // ----
  initial begin
    void'($urandom(32'he3b6));
    tick(8);
    rst_b <= 1;
    tick(1);
    rc("enable", ADDR_KEY_WAKE_ENABLE, 32'h0, RESP_OKAY);
    axw(ADDR_KEY_WAKE_ENABLE, 32'hf0);
    rc("enableWo", ADDR_KEY_WAKE_ENABLE, 32'h0, RESP_OKAY);
    rc("unmapped", 16'h0010, 32'h0, RESP_SLVERR);
    axw(16'h0010, 32'h3);
    axw(ADDR_MASK, 32'h3);
    $display("test 1 done");
    for (int i = 0; i < KEYS; i++) begin
      j = (i + 1 + $urandom % 3) % KEYS;
      axw(ADDR_KEY_WAKE_ENABLE, 32'h10 << i);
      rc("pins", ADDR_PINS, 32'hf0, RESP_OKAY);
      axw(ADDR_CONTROL, 32'h3);
      chk("enter", 1, standbyActive);
      keyPress <= 4'(1 << j);
      tick(4);
      chk("disabledKey", 1, standbyActive);
      chk("noRequest", relModel(relLevel, keyPress), releaseRequest);
      keyPress <= 4'(1 << i);
      waitRel;
      warmExp++;
      chk("keyWake", 0, standbyActive);
      chk("warmup", warmExp, warmSeen);
      chk("irq", 1, irq);
      rc("status", ADDR_STATUS, 32'h1, RESP_OKAY);
      chk("irqClear", 0, irq);
      keyPress <= '0;
      $display("test 2 key %0d done", i);
    end
    relLevel <= 1;
    axw(ADDR_CONTROL, 32'h3);
    tick(1);
    warmExp++;
    chk("blocked", 0, standbyActive);
    chk("blockRequest", relModel(relLevel, keyPress), releaseRequest);
    chk("blockWarm", warmExp, warmSeen);
    rc("blockStatus", ADDR_STATUS, 32'h2, RESP_OKAY);
    relLevel <= 0;
    $display("test 3 done");
    axw(ADDR_KEY_WAKE_ENABLE, 32'h0);
    axw(ADDR_MASK, 32'h2);
    axw(ADDR_CONTROL, 32'h2);
    chk("edgeEnter", 1, standbyActive);
    rc("control", ADDR_CONTROL, 32'h0, RESP_OKAY);
    tick(3);
    relLevel <= 1;
    waitRel;
    warmExp++;
    chk("edgeWake", 0, standbyActive);
    chk("edgeWarm", warmExp, warmSeen);
    chk("irqMasked", 0, irq);
    rc("edgeStatus", ADDR_STATUS, 32'h1, RESP_OKAY);
    $display("test 4 done");
    conclude();
  end
  initial begin
    #200us;
    errCount++;
    conclude();
  end
endmodule : testbench
